// [hdl/ssdl_defines.vh]
// register map, field positions, reset values and counter constants of the stall detector logic
`ifndef SSDL_DEFINES_VH
`define SSDL_DEFINES_VH

// register indices; byte address is four times the index
`define SSDL_IDX_RETURN_ZERO_CONTROL      3'h0
`define SSDL_IDX_DOWN_COUNTER_CONTROL      3'h1
`define SSDL_IDX_SSDCTL      3'h2
`define SSDL_IDX_FLAGS       3'h3
`define SSDL_IDX_COUNT       3'h4
`define SSDL_ADDR_W          5

// return_zero_control fields
`define SSDL_RZ_INTEGRATE    7
`define SSDL_RZ_COIL_DRIVE   6
`define SSDL_RZ_RECIRC       5
`define SSDL_RZ_POLARITY     4
`define SSDL_RZ_MOTOR_SEL    2
`define SSDL_RZ_STEP_HI      1
`define SSDL_RZ_STEP_LO      0
`define SSDL_RZ_RESET        8'h00

// down_counter_control fields
`define SSDL_DC_UF_IRQ_EN    7
`define SSDL_DC_RELOAD       6
`define SSDL_DC_READ_LOAD    5
`define SSDL_DC_PRESCALE     4
`define SSDL_DC_FORCE_LOAD   3
`define SSDL_DC_ENABLE       2
`define SSDL_DC_OV_IRQ_EN    0
`define SSDL_DC_RESET        8'h00

// stall detector control and flag fields
`define SSDL_SC_RTZ_ENABLE   7
`define SSDL_SC_RESET        1'b0
`define SSDL_FL_UNDERFLOW    7
`define SSDL_FL_OVERFLOW     0

// down counter constants
`define SSDL_CNT_PRESET      16'hFFFF
`define SSDL_CNT_ZERO        16'h0000
`define SSDL_CNT_ONE         16'h0001
`define SSDL_LOAD_RESET      16'h0000
`define SSDL_DIV_FAST_LAST   9'h03F
`define SSDL_DIV_SLOW_LAST   9'h1FF

// bus responses
`define SSDL_RESP_OKAY       2'h0
`define SSDL_RESP_SLVERR     2'h2

`endif

// [hdl/ssdl_bridge_decode.v]
// decode of step, drive, recirculation and polarity into transistor and switch commands
`timescale 1ns/10ps
module ssdl_bridge_decode (
  input  wire       mclk,          // bus clock
  input  wire       sys_rst,       // async reset, active high
  input  wire [7:0] rzCtl,         // return_zero_control contents
  input  wire       rtzEnable,     // return_zero_enable
  output reg  [7:0] motorATrans,   // motor A transistors T1..T8, 1 = on
  output reg  [7:0] motorBTrans,   // motor B transistors T1..T8, 1 = on
  output reg  [7:0] motorASw,      // motor A switches S1..S8, 1 = closed
  output reg  [7:0] motorBSw,      // motor B switches S1..S8, 1 = closed
  output reg        motorARtz,     // motor A coils under control
  output reg        motorBRtz      // motor B coils under control
);
`include "ssdl_defines.vh"

  wire [1:0] step      = rzCtl[`SSDL_RZ_STEP_HI:`SSDL_RZ_STEP_LO];
  wire       integ     = rzCtl[`SSDL_RZ_INTEGRATE];
  wire       drive     = rzCtl[`SSDL_RZ_COIL_DRIVE];
  wire       recirc    = rzCtl[`SSDL_RZ_RECIRC];
  wire       polarity  = rzCtl[`SSDL_RZ_POLARITY];
  wire       motorSel  = rzCtl[`SSDL_RZ_MOTOR_SEL];
  reg  [3:0] drvPair;
  reg  [3:0] recPair;
  reg  [7:0] next_trans;
  reg  [7:0] next_sw;

  // transistor decode: driven coil by step, other coil blanked or floated
  always @*
  begin
    drvPair = 4'h0;
    if (drive)                                    // RULE6
      drvPair = step[1] ? 4'h6 : 4'h9;            // RULE3
    recPair = 4'h0;
    if (!integ)                                   // RULE3
      recPair = recirc ? 4'hA : 4'h5;             // RULE17
    next_trans = 8'h00;
    if (rtzEnable)                                // RULE18
      next_trans = step[0] ? {drvPair, recPair} : {recPair, drvPair};
  end

  // switch decode: ends of the non-driven coil to integrator and reference
  always @*
  begin
    next_sw = 8'h00;
    if (integ)                                    // RULE4
    begin
      if (step[0])
        next_sw = (step[1] ^ polarity) ? 8'h09 : 8'h06;  // RULE5
      else
        next_sw = (step[1] ^ polarity) ? 8'h60 : 8'h90;  // RULE5
    end
  end

  // per motor output registers, only the selected motor is driven
  genvar m;
  generate
    for (m = 0; m < 2; m = m + 1)
    begin : gMotor
      wire hit = (motorSel == (m != 0));          // RULE1
      if (m == 0)
      begin : gA
        always @(posedge mclk or posedge sys_rst)
        begin
          if (sys_rst)
          begin
            motorATrans <= 8'h00;
            motorASw    <= 8'h00;
            motorARtz   <= 1'b0;
          end
          else
          begin
            motorATrans <= hit ? next_trans : 8'h00;  // RULE21
            motorASw    <= hit ? next_sw : 8'h00;
            motorARtz   <= hit & rtzEnable;
          end
        end
      end
      else
      begin : gB
        always @(posedge mclk or posedge sys_rst)
        begin
          if (sys_rst)
          begin
            motorBTrans <= 8'h00;
            motorBSw    <= 8'h00;
            motorBRtz   <= 1'b0;
          end
          else
          begin
            motorBTrans <= hit ? next_trans : 8'h00;  // RULE21
            motorBSw    <= hit ? next_sw : 8'h00;
            motorBRtz   <= hit & rtzEnable;
          end
        end
      end
    end
  endgenerate
endmodule

// [hdl/ssdl_down_counter.v]
// 16-bit modulus down counter with prescaler, reload mode and force load
`timescale 1ns/10ps
module ssdl_down_counter (
  input  wire        mclk,         // bus clock
  input  wire        sys_rst,      // async reset, active high
  input  wire        enable,       // down_counter_enable
  input  wire        reloadMode,   // reload_mode_enable
  input  wire        slowPrescale, // prescale select, 1 = divide by 512
  input  wire        forceLoad,    // one-cycle force_load pulse
  input  wire        cntWrite,     // one-cycle write of the count register
  input  wire [15:0] cntData,      // value written to the count register
  output reg  [15:0] countValue,   // live count
  output reg  [15:0] loadValue,    // load register
  output reg         underflow     // one-cycle pulse on reaching zero
);
`include "ssdl_defines.vh"

  reg  [8:0]  divCount;
  reg         slowActive;
  wire [8:0]  divLast  = slowActive ? `SSDL_DIV_SLOW_LAST : `SSDL_DIV_FAST_LAST;
  wire        tick     = enable && (divCount == divLast);
  wire [15:0] newLoad  = cntWrite ? cntData : loadValue;
  wire        wrLoad   = cntWrite && !reloadMode;
  wire        reachZero = tick && (countValue == `SSDL_CNT_ONE);

  // prescaler, restarted by every transfer into the count register
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      divCount <= 9'h000;
    else if (!enable || forceLoad || wrLoad || tick)
      divCount <= 9'h000;
    else
      divCount <= divCount + 9'h001;
  end

  // load register, counter and the ratio in force
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loadValue  <= `SSDL_LOAD_RESET;
      countValue <= `SSDL_CNT_PRESET;
      slowActive <= 1'b0;
      underflow  <= 1'b0;
    end
    else
    begin
      loadValue <= newLoad;
      underflow <= reachZero;                              // RULE19
      if (!enable)
        countValue <= `SSDL_CNT_PRESET;                    // RULE15
      else if (forceLoad || wrLoad)                        // RULE14
      begin
        countValue <= newLoad;
        slowActive <= slowPrescale;                        // RULE13
      end
      else if (reachZero && reloadMode)                    // RULE9
      begin
        countValue <= newLoad;
        slowActive <= slowPrescale;                        // RULE13
      end
      else if (tick && countValue != `SSDL_CNT_ZERO)       // RULE8
        countValue <= countValue - `SSDL_CNT_ONE;          // RULE20
    end
  end
endmodule

// [hdl/ssdl_top.v]
// stall detector drive decode and modulus down counter behind an AXI4-Lite slave
//
// Summary of operation
// RULE1: motor select bit picks motor A or B
// RULE2: step field gives east, north, west, south
// RULE3: drive coil by step, float on integrate
// RULE4: integrate clear opens all converter switches
// RULE5: polarity swaps integrator and reference coil ends
// RULE6: drive clear gives zero coil current
// RULE7: underflow irq follows flag and enable bit
// RULE8: without reload counter stops at zero
// RULE9: reload mode reloads latest load value
// RULE10: software disables counter before changing reload mode
// RULE11: read select returns count or load
// RULE12: prescale divides bus clock by 64 or 512
// RULE13: new prescale ratio applies at next load
// RULE14: force load copies load now, reads zero
// RULE15: disabled counter stops and presets to FFFF
// RULE16: overflow irq follows flag and enable bit
// RULE17: recirculation bit picks high or low side
// RULE18: coils driven only while return-to-zero enabled
// RULE19: underflow sets flag, write one clears it
// RULE20: counter decrements per tick, controls reset zero
// RULE21: decode goes only to selected motor pins
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module ssdl_top (
  input  wire        mclk,           // bus clock, 100 MHz
  input  wire        sys_rst,        // async reset, active high
  input  wire [4:0]  s_axi_awaddr,   // write address
  input  wire        s_axi_awvalid,  // write address valid
  output reg         s_axi_awready,  // write address ready
  input  wire [31:0] s_axi_wdata,    // write data
  input  wire [3:0]  s_axi_wstrb,    // write byte enables
  input  wire        s_axi_wvalid,   // write data valid
  output reg         s_axi_wready,   // write data ready
  output reg  [1:0]  s_axi_bresp,    // write response
  output reg         s_axi_bvalid,   // write response valid
  input  wire        s_axi_bready,   // write response ready
  input  wire [4:0]  s_axi_araddr,   // read address
  input  wire        s_axi_arvalid,  // read address valid
  output reg         s_axi_arready,  // read address ready
  output reg  [31:0] s_axi_rdata,    // read data
  output reg  [1:0]  s_axi_rresp,    // read response
  output reg         s_axi_rvalid,   // read data valid
  input  wire        s_axi_rready,   // read data ready
  input  wire        overflowEvent,  // accumulator overflow pulse, same clock
  output reg         underflowIrq,   // underflow interrupt request
  output reg         overflowIrq,    // overflow interrupt request
  output wire [7:0]  motorATrans,    // motor A transistors T1..T8
  output wire [7:0]  motorBTrans,    // motor B transistors T1..T8
  output wire [7:0]  motorASw,       // motor A switches S1..S8
  output wire [7:0]  motorBSw,       // motor B switches S1..S8
  output wire        motorARtz,      // motor A under return-to-zero control
  output wire        motorBRtz       // motor B under return-to-zero control
);
`include "ssdl_defines.vh"

  reg  [7:0]  rzCtl;
  reg  [7:0]  dcCtl;
  reg         rtzEnable;
  reg         underflowFlag;
  reg         overflowFlag;
  reg         forceLoad;
  reg         cntWrite;
  reg  [15:0] cntData;
  reg  [4:0]  awAddr;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg         awHeld;
  reg         wHeld;
  reg  [31:0] next_rdata;
  reg         next_rerr;
  wire [15:0] countValue;
  wire [15:0] loadValue;
  wire        underflowPulse;
  wire [2:0]  wIdx = awAddr[4:2];
  wire [2:0]  rIdx = s_axi_araddr[4:2];
  wire        doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire        wMapped = (awAddr[1:0] == 2'h0) && (wIdx <= `SSDL_IDX_COUNT);
  wire        lane0 = doWrite && wMapped && wStrb[0];
  wire        lane1 = doWrite && wMapped && wStrb[1];
  wire        clrUnder = lane0 && (wIdx == `SSDL_IDX_FLAGS) && wData[`SSDL_FL_UNDERFLOW];
  wire        clrOver = lane0 && (wIdx == `SSDL_IDX_FLAGS) && wData[`SSDL_FL_OVERFLOW];

  // write address channel: taken once, held until the response is issued
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awHeld        <= 1'b0;
      awAddr        <= 5'h00;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      else if (doWrite)
        awHeld <= 1'b0;
    end
  end

  // write data channel: taken once, held until the response is issued
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wHeld        <= 1'b0;
      wData        <= 32'h00000000;
      wStrb        <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      else if (doWrite)
        wHeld <= 1'b0;
    end
  end

  // write response, error for an unmapped or unaligned address
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SSDL_RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wMapped ? `SSDL_RESP_OKAY : `SSDL_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // control registers, all cleared by reset
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rzCtl     <= `SSDL_RZ_RESET;                 // RULE20
      dcCtl     <= `SSDL_DC_RESET;                 // RULE20
      rtzEnable <= `SSDL_SC_RESET;
    end
    else if (lane0)
    begin
      if (wIdx == `SSDL_IDX_RETURN_ZERO_CONTROL)
        rzCtl <= {wData[7:4], 1'b0, wData[2:0]};   // RULE2
      if (wIdx == `SSDL_IDX_DOWN_COUNTER_CONTROL)
        dcCtl <= {wData[7:4], 1'b0, wData[2], 1'b0, wData[0]};  // RULE14
      if (wIdx == `SSDL_IDX_SSDCTL)
        rtzEnable <= wData[`SSDL_SC_RTZ_ENABLE];
    end
  end

  // one-cycle strobes toward the counter
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      forceLoad <= 1'b0;
      cntWrite  <= 1'b0;
      cntData   <= `SSDL_LOAD_RESET;
    end
    else
    begin
      forceLoad <= lane0 && (wIdx == `SSDL_IDX_DOWN_COUNTER_CONTROL) && wData[`SSDL_DC_FORCE_LOAD];  // RULE14
      cntWrite  <= (lane0 || lane1) && (wIdx == `SSDL_IDX_COUNT);
      cntData   <= {lane1 ? wData[15:8] : loadValue[15:8],
                    lane0 ? wData[7:0] : loadValue[7:0]};
    end
  end

  // sticky flags: hardware set wins over a write-one clear
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      underflowFlag <= 1'b0;
      overflowFlag  <= 1'b0;
    end
    else
    begin
      if (underflowPulse)
        underflowFlag <= 1'b1;                     // RULE19
      else if (clrUnder)
        underflowFlag <= 1'b0;                     // RULE19
      if (overflowEvent)
        overflowFlag <= 1'b1;
      else if (clrOver)
        overflowFlag <= 1'b0;
    end
  end

  // interrupt requests gated by their enables
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      underflowIrq <= 1'b0;
      overflowIrq  <= 1'b0;
    end
    else
    begin
      underflowIrq <= underflowFlag && dcCtl[`SSDL_DC_UF_IRQ_EN];  // RULE7
      overflowIrq  <= overflowFlag && dcCtl[`SSDL_DC_OV_IRQ_EN];   // RULE16
    end
  end

  // read data multiplexer
  always @*
  begin
    next_rdata = 32'h00000000;
    next_rerr  = 1'b0;
    if (s_axi_araddr[1:0] != 2'h0)
      next_rerr = 1'b1;
    else
    begin
      case (rIdx)
        `SSDL_IDX_RETURN_ZERO_CONTROL:
          next_rdata[7:0] = rzCtl;
        `SSDL_IDX_DOWN_COUNTER_CONTROL:
          next_rdata[7:0] = dcCtl;
        `SSDL_IDX_SSDCTL:
          next_rdata[`SSDL_SC_RTZ_ENABLE] = rtzEnable;
        `SSDL_IDX_FLAGS:
        begin
          next_rdata[`SSDL_FL_UNDERFLOW] = underflowFlag;
          next_rdata[`SSDL_FL_OVERFLOW]  = overflowFlag;
        end
        `SSDL_IDX_COUNT:
          next_rdata[15:0] = dcCtl[`SSDL_DC_READ_LOAD] ? loadValue : countValue;  // RULE11
        default:
          next_rerr = 1'b1;
      endcase
    end
  end

  // read channel: one read under way, data registered with the response
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SSDL_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rerr ? `SSDL_RESP_SLVERR : `SSDL_RESP_OKAY;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // modulus down counter
  ssdl_down_counter uCounter (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .enable       (dcCtl[`SSDL_DC_ENABLE]),       // RULE15
    .reloadMode   (dcCtl[`SSDL_DC_RELOAD]),       // RULE9
    .slowPrescale (dcCtl[`SSDL_DC_PRESCALE]),     // RULE12
    .forceLoad    (forceLoad),
    .cntWrite     (cntWrite),
    .cntData      (cntData),
    .countValue   (countValue),
    .loadValue    (loadValue),
    .underflow    (underflowPulse)
  );

  // coil transistor and converter switch decode
  ssdl_bridge_decode uDecode (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .rzCtl       (rzCtl),
    .rtzEnable   (rtzEnable),                     // RULE18
    .motorATrans (motorATrans),
    .motorBTrans (motorBTrans),
    .motorASw    (motorASw),
    .motorBSw    (motorBSw),
    .motorARtz   (motorARtz),
    .motorBRtz   (motorBRtz)
  );
endmodule

// [sim/ssdl_props.sv]
// assertion checker on the stall detector top ports
`timescale 1ns/10ps
module ssdl_props (
  input logic        mclk,          // bus clock
  input logic        sys_rst,       // async reset
  input logic        s_axi_arvalid, // read address valid
  input logic        s_axi_arready, // read address ready
  input logic        s_axi_rvalid,  // read data valid
  input logic        s_axi_rready,  // read data ready
  input logic [31:0] s_axi_rdata,   // read data
  input logic        s_axi_bvalid,  // write response valid
  input logic        overflowEvent, // overflow pulse
  input logic        underflowIrq,  // underflow request
  input logic        overflowIrq,   // overflow request
  input logic [7:0]  motorATrans,   // motor A transistors
  input logic [7:0]  motorBTrans,   // motor B transistors
  input logic [7:0]  motorASw,      // motor A switches
  input logic [7:0]  motorBSw,      // motor B switches
  input logic        motorARtz,     // motor A controlled
  input logic        motorBRtz      // motor B controlled
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // read handshake steps
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_hold;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  // bus answer timing, then decode and request relations
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_stands: assert property (s_rd_hold |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_one_motor: assert property (!(motorARtz && motorBRtz))
    else $error("both motors under control");
  a_free_coils: assert property ((motorARtz || motorATrans == 8'h00) && (motorBRtz || motorBTrans == 8'h00))
    else $error("coils driven without control");
  a_no_shoot: assert property ((motorATrans & {motorATrans[6:0], 1'h0} & 8'hAA) == 8'h00)
    else $error("half bridge shoot through");
  a_sw_codes: assert property (motorASw inside {8'h00, 8'h90, 8'h60, 8'h06, 8'h09})
    else $error("illegal switch pattern");
  a_sw_one_motor: assert property (motorASw == 8'h00 || motorBSw == 8'h00)
    else $error("switches closed on both motors");
  a_ov_irq_src: assert property ($rose(overflowIrq) |->
    $past(overflowEvent, 2) || $past(overflowEvent, 3) || $past(s_axi_bvalid))
    else $error("overflow request without cause");
  a_irq_fall_wr: assert property ($fell(underflowIrq) || $fell(overflowIrq) |-> $past(s_axi_bvalid))
    else $error("request dropped without write");
endmodule

// [sim/ssdl_coil_model.sv]
// coil current model of one stepper motor behind its H-bridges
`timescale 1ns/10ps
module ssdl_coil_model (
  input  logic [7:0] trans, // transistors T1..T8, 1 = on
  output logic [1:0] sinI,  // sine coil current, two's complement
  output logic [1:0] cosI   // cosine coil current, two's complement
);
  // full current flows only through a diagonal pair of one bridge
  always_comb
  begin
    sinI = (trans[0] & trans[3]) ? 2'h1 : ((trans[1] & trans[2]) ? 2'h3 : 2'h0);
    cosI = (trans[4] & trans[7]) ? 2'h1 : ((trans[5] & trans[6]) ? 2'h3 : 2'h0);
  end
endmodule

// [sim/ssdl_top_test.sv]
// self-checking bench of the stall detector top
`timescale 1ns/10ps
module ssdl_top_test;
  logic        mclk = 1'h0, sys_rst = 1'h1, overflowEvent = 1'h0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, rz;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, sinI, cosI;
  logic        underflowIrq, overflowIrq, motorARtz, motorBRtz, onA, onB;
  logic [7:0]  motorATrans, motorBTrans, motorASw, motorBSw;
  logic [31:0] seed = 32'h000135AA;
  int          fail_count = 0, checked = 0, c;
  ssdl_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .overflowEvent(overflowEvent), .underflowIrq(underflowIrq), .overflowIrq(overflowIrq),
    .motorATrans(motorATrans), .motorBTrans(motorBTrans), .motorASw(motorASw), .motorBSw(motorBSw),
    .motorARtz(motorARtz), .motorBRtz(motorBRtz));
  ssdl_coil_model u_coil (.trans(motorATrans), .sinI(sinI), .cosI(cosI));
  // clock and shared tasks
  always #5 mclk = ~mclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] expTrans(input logic [7:0] z);
    logic [3:0] d, q;
    d = z[6] ? (z[1] ? 4'h6 : 4'h9) : 4'h0;
    q = z[7] ? 4'h0 : (z[5] ? 4'hA : 4'h5);
    return z[0] ? {d, q} : {q, d};
  endfunction
  function automatic logic [7:0] expSw(input logic [7:0] z);
    if (!z[7])
      return 8'h00;
    if (z[0])
      return (z[1] ^ z[4]) ? 8'h09 : 8'h06;
    return (z[1] ^ z[4]) ? 8'h60 : 8'h90;
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task guard(input logic t);
    if (t)
    begin
      fail_count++;
      print_verdict();
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid && n < 60);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    guard(n >= 60);
  endtask
  task rd(input logic [4:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= seed[3];
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && !s_axi_rready)
        s_axi_rready <= 1'h1;
    end
    while (!(s_axi_rvalid && s_axi_rready) && n < 60);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    guard(n >= 60);
  endtask
  task waitIrq;
    c = 0;
    while (!underflowIrq && c < 2000)
    begin
      @(posedge mclk);
      c++;
    end
    guard(c >= 2000);
  endtask
  task meas(input logic [15:0] n);
    wr(5'h0C, 32'h81);
    wr(5'h10, {16'h0, n});
    waitIrq();
  endtask
  task pulse;
    @(posedge mclk);
    overflowEvent <= 1'h1;
    @(posedge mclk);
    overflowEvent <= 1'h0;
    repeat (4) @(posedge mclk);
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'h0;
    for (logic [4:0] a = 5'h00; a < 5'h10; a += 5'h04)
    begin
      rd(a);
      chk("reset value", v, 32'h0);
    end
    rd(5'h10);
    chk("count preset", v, 32'h0000FFFF);
    rd(5'h14);
    chk("unmapped resp", r, 2'h2);
    wr(5'h02, 32'hFF);
    chk("unaligned resp", r, 2'h2);
    $display("test reset done");
    for (int i = 0; i < 40; i++)
    begin
      rz = xs();
      wr(5'h00, {24'h0, rz[7:0]});
      wr(5'h08, {24'h0, rz[8], 7'h0});
      repeat (2) @(posedge mclk);
      onA = rz[8] & ~rz[2];
      onB = rz[8] & rz[2];
      chk("rtz A", motorARtz, onA);
      chk("rtz B", motorBRtz, onB);
      chk("trans A", motorATrans, onA ? expTrans(rz[7:0]) : 8'h00);
      chk("trans B", motorBTrans, onB ? expTrans(rz[7:0]) : 8'h00);
      chk("sw A", motorASw, rz[2] ? 8'h00 : expSw(rz[7:0]));
      chk("sw B", motorBSw, rz[2] ? expSw(rz[7:0]) : 8'h00);
      chk("sine I", sinI, (onA & rz[6] & ~rz[0]) ? (rz[1] ? 2'h3 : 2'h1) : 2'h0);
      chk("cosine I", cosI, (onA & rz[6] & rz[0]) ? (rz[1] ? 2'h3 : 2'h1) : 2'h0);
      rd(5'h00);
      chk("rz read", v, {24'h0, rz[7:0] & 8'hF7});
    end
    $display("test decode done");
    wr(5'h04, 32'h84);
    meas(16'h0003);
    chk("tick 64", c >= 190 && c <= 200, 1'h1);
    repeat (150) @(posedge mclk);
    rd(5'h10);
    chk("stop zero", v, 32'h0);
    rd(5'h0C);
    chk("flag set", v[7], 1'h1);
    wr(5'h0C, 32'h00);
    chk("irq held", underflowIrq, 1'h1);
    wr(5'h04, 32'h04);
    repeat (2) @(posedge mclk);
    chk("irq masked", underflowIrq, 1'h0);
    wr(5'h04, 32'hA4);
    rd(5'h10);
    chk("load read", v, 32'h3);
    wr(5'h04, 32'h8C);
    rd(5'h04);
    chk("force reads 0", v, 32'h84);
    rd(5'h10);
    chk("forced count", v, 32'h3);
    wr(5'h0C, 32'h80);
    repeat (2) @(posedge mclk);
    chk("flag cleared", underflowIrq, 1'h0);
    wr(5'h04, 32'h80);
    rd(5'h10);
    chk("disabled", v, 32'h0000FFFF);
    wr(5'h04, 32'h84);
    wr(5'h10, 32'h2);
    wr(5'h04, 32'h94);
    waitIrq();
    chk("old ratio", c < 150, 1'h1);
    meas(16'h0001);
    chk("tick 512", c >= 508 && c <= 520, 1'h1);
    $display("test counter done");
    wr(5'h04, 32'h80);
    wr(5'h04, 32'hC0);
    wr(5'h04, 32'hC4);
    wr(5'h10, 32'h2);
    rd(5'h10);
    chk("load only", v[15:8], 8'hFF);
    wr(5'h04, 32'hCC);
    wr(5'h0C, 32'h81);
    repeat (700) @(posedge mclk);
    rd(5'h10);
    chk("reloading", v == 32'h1 || v == 32'h2, 1'h1);
    rd(5'h0C);
    chk("reload flag", v[7], 1'h1);
    wr(5'h10, 32'h1);
    repeat (300) @(posedge mclk);
    rd(5'h10);
    chk("latest load", v, 32'h1);
    $display("test reload done");
    wr(5'h04, 32'h40);
    wr(5'h04, 32'h01);
    pulse();
    chk("ov irq", overflowIrq, 1'h1);
    wr(5'h0C, 32'h01);
    repeat (2) @(posedge mclk);
    chk("ov cleared", overflowIrq, 1'h0);
    wr(5'h04, 32'h00);
    pulse();
    chk("ov masked", overflowIrq, 1'h0);
    rd(5'h0C);
    chk("ov flag", v[0], 1'h1);
    $display("test overflow done");
    print_verdict();
  end
endmodule
bind ssdl_top ssdl_props u_props (.mclk(mclk), .sys_rst(sys_rst), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .overflowEvent(overflowEvent),
  .underflowIrq(underflowIrq), .overflowIrq(overflowIrq), .motorATrans(motorATrans), .motorBTrans(motorBTrans),
  .motorASw(motorASw), .motorBSw(motorBSw), .motorARtz(motorARtz), .motorBRtz(motorBRtz));
